/* File: design/bcrb_pkg.sv */
package bcrb_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_TIME  = 8'h00;
  localparam logic [7:0] OFS_DATE  = 8'h04;
  localparam logic [7:0] OFS_CTRL  = 8'h08;
  localparam logic [7:0] OFS_PRESC = 8'h0c;
  localparam logic [7:0] OFS_SUBS  = 8'h10;
  localparam logic [7:0] OFS_SHIFT = 8'h14;
  localparam logic [7:0] OFS_CALIB = 8'h18;
  localparam logic [7:0] OFS_ALARM = 8'h1c;
  localparam logic [7:0] OFS_STS   = 8'h24;
  localparam logic [7:0] OFS_MASK  = 8'h28;
  localparam logic [7:0] OFS_TSTM  = 8'h2c;
  localparam logic [7:0] OFS_TSDT  = 8'h30;
  localparam logic [7:0] OFS_TSSS  = 8'h34;
  localparam logic [7:0] OFS_BKP   = 8'h40;
  // Control, shift and status fields
  localparam int CTL_EN     = 0;
  localparam int CTL_FMT12  = 1;
  localparam int CTL_SEL    = 2;
  localparam int CTL_REFEN  = 4;
  localparam int CTL_REF60  = 5;
  localparam int CTL_ALREN  = 6;
  localparam int CTL_TSEN   = 7;
  localparam int CTL_TAMPEN = 8;
  localparam int CTL_FILT   = 10;
  localparam int CTL_TAMPTS = 12;
  localparam int SHF_ADD1S  = 31;
  localparam int STS_ALARM  = 0;
  localparam int STS_TS     = 1;
  localparam int STS_TAMP   = 2;
  // Reset values and counts
  localparam logic [31:0] RST_TIME  = 32'h0000_0000;
  localparam logic [31:0] RST_DATE  = 32'h0000_2101;
  localparam logic [31:0] RST_CTRL  = 32'h0000_0000;
  localparam logic [6:0]  RST_PREA  = 7'h7f;
  localparam logic [14:0] RST_PRES  = 15'h00ff;
  localparam logic [4:0]  HSE_DIV_M1 = 5'h1f;
  localparam logic [5:0]  REF_CNT50 = 6'h31;
  localparam logic [5:0]  REF_CNT60 = 6'h3b;
  localparam logic [31:0] TM_CMP_MASK = 32'h007f_7f7f;
  typedef enum logic [1:0] {
    CS_LSE = 2'b00, CS_EXT = 2'b01, CS_LSI = 2'b10, CS_HSE = 2'b11
  } bcrb_clksel_t;
  typedef struct packed {
    logic [8:0] rsv;
    logic       pm;
    logic [5:0] hr;
    logic       r1;
    logic [6:0] mn;
    logic       r0;
    logic [6:0] sc;
  } bcrb_tm_t;
  typedef struct packed {
    logic [7:0] rsv;
    logic [7:0] yr;
    logic [2:0] wd;
    logic [4:0] mo;
    logic [1:0] r0;
    logic [5:0] dy;
  } bcrb_dt_t;
endpackage

/* File: design/bcrb_rtc.sv */
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// - Five 32-bit backup words, twenty bytes
// - Backup words ignore every reset source
// - BCD calendar, 12 or 24 hour
// - Month length follows month and leap year
// - Alarm match flags event and wakes
// - Shift correction of 1 to 32767 pulses
// - Calibration masks pulses in ppm steps
// - Two filtered tamper inputs that wake
// - Timestamp captures calendar on pin/tamper
// - Timestamp event wakes the system
// - Optional 50/60 Hz reference second
// - Four selectable timekeeper clock sources
module bcrb_rtc import bcrb_pkg::*; #(
  parameter int N_BKP  = 5,
  parameter int N_TAMP = 2
) (
  input  wire logic              clk_sys_i,
  input  wire logic              arst_n_i,
  input  wire logic              ce_i,
  input  wire logic [7:0]        addr_i,
  input  wire logic [31:0]       wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [31:0]       rdata_o,
  input  wire logic              lse_tick_i,
  input  wire logic              ext_tick_i,
  input  wire logic              lsi_tick_i,
  input  wire logic              hse_tick_i,
  input  wire logic              ref_i,
  input  wire logic [N_TAMP-1:0] tamp_i,
  input  wire logic              ts_i,
  output logic                   irq_o,
  output logic                   wake_o
);
  localparam int NS = 2 + N_TAMP;
  if (N_BKP < 1 || N_BKP > 8) $error("N_BKP out of range");
  if (N_TAMP < 1 || N_TAMP > 4) $error("N_TAMP out of range");

  // --------------------------------------------------------
  // Reset release
  // --------------------------------------------------------
  logic [1:0] rst_sync;
  logic       rst_n;
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) rst_sync <= 2'b00;
    else rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // --------------------------------------------------------
  // Register state
  // --------------------------------------------------------
  bcrb_tm_t        tm, next_tm, alarm, ts_tm;
  bcrb_dt_t        dt, next_dt, ts_dt;
  logic [31:0]     ctrl;
  logic [6:0]      prea;
  logic [14:0]     pres;
  logic [8:0]      calm;
  logic [14:0]     ts_ss;
  logic [NS-1:0]   sts, msk, ev;
  logic [31:0]     bkp [N_BKP] = '{default: 32'h0000_0000};
  logic            we, tick, alr_ev, ts_ev, ref_sec, shf_add;
  logic            wr_tm, wr_dt, wr_shf;
  logic [N_TAMP-1:0] tmp_ev;

  assign we     = wr_i && ce_i;
  assign wr_tm  = we && addr_i == OFS_TIME;
  assign wr_dt  = we && addr_i == OFS_DATE;
  assign wr_shf = we && addr_i == OFS_SHIFT;

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl  <= RST_CTRL;
      prea  <= RST_PREA;
      pres  <= RST_PRES;
      calm  <= 9'h000;
      alarm <= RST_TIME;
      msk   <= '0;
    end else if (we) begin
      case (addr_i)
        OFS_CTRL:  ctrl <= wdata_i;
        OFS_PRESC: {prea, pres} <= {wdata_i[22:16], wdata_i[14:0]};
        OFS_CALIB: calm <= wdata_i[8:0];
        OFS_ALARM: alarm <= wdata_i & TM_CMP_MASK;
        OFS_MASK:  msk <= wdata_i[NS-1:0];
        default:   ;
      endcase
    end
  end

  // Backup words: no reset, kept across all resets
  always_ff @(posedge clk_sys_i) begin
    for (int i = 0; i < N_BKP; i++) begin
      if (we && addr_i == OFS_BKP + 8'(4 * i)) bkp[i] <= wdata_i;
    end
  end

  // --------------------------------------------------------
  // Clock source and calibration
  // --------------------------------------------------------
  logic [4:0]  hse_div;
  logic        raw, pulse;
  logic [19:0] cal_win;
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) hse_div <= 5'h00;
    else if (ce_i && hse_tick_i) begin
      hse_div <= (hse_div == HSE_DIV_M1) ? 5'h00 : hse_div + 5'h01;
    end
  end
  always_comb begin
    case (bcrb_clksel_t'(ctrl[CTL_SEL +: 2]))
      CS_LSE:  raw = lse_tick_i;
      CS_EXT:  raw = ext_tick_i;
      CS_LSI:  raw = lsi_tick_i;
      CS_HSE:  raw = hse_tick_i && hse_div == HSE_DIV_M1;
      default: raw = 1'b0;
    endcase
    raw = raw && ctrl[CTL_EN] && ce_i;
  end
  // One pulse dropped per 2^11 window slot, calm slots per 2^20
  assign pulse = raw && !(cal_win[10:0] == 11'h000 && cal_win[19:11] < calm);
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) cal_win <= 20'h00000;
    else if (raw) cal_win <= cal_win + 20'h00001;
  end

  // --------------------------------------------------------
  // Prescalers and reference second
  // --------------------------------------------------------
  logic [6:0]  apre_cnt;
  logic [14:0] ss_cnt;
  logic        ss_wrap, ref_q;
  logic [5:0]  ref_cnt;
  assign ss_wrap = pulse && apre_cnt == 7'h00 && ss_cnt == 15'h0000;
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      apre_cnt <= RST_PREA;
      ss_cnt   <= RST_PRES;
    end else if (wr_tm || ref_sec) begin
      apre_cnt <= prea;
      ss_cnt   <= pres;
    end else if (wr_shf && wdata_i[14:0] != 15'h0000) begin
      ss_cnt <= ss_cnt + wdata_i[14:0];
    end else if (pulse) begin
      apre_cnt <= (apre_cnt == 7'h00) ? prea : apre_cnt - 7'h01;
      if (apre_cnt == 7'h00) ss_cnt <= (ss_cnt == 15'h0000) ? pres : ss_cnt - 15'h0001;
    end
  end
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      ref_q   <= 1'b0;
      ref_cnt <= 6'h00;
    end else if (ce_i) begin
      ref_q <= ref_i;
      if (!ctrl[CTL_REFEN] || ref_sec) ref_cnt <= 6'h00;
      else if (ref_i && !ref_q) ref_cnt <= ref_cnt + 6'h01;
    end
  end
  assign ref_sec = ce_i && ctrl[CTL_EN] && ctrl[CTL_REFEN] && ref_i && !ref_q
                   && ref_cnt == (ctrl[CTL_REF60] ? REF_CNT60 : REF_CNT50);
  assign shf_add = wr_shf && wdata_i[SHF_ADD1S] && ctrl[CTL_EN];
  assign tick = (ss_wrap && !ctrl[CTL_REFEN]) || ref_sec || shf_add;

  // --------------------------------------------------------
  // Calendar
  // --------------------------------------------------------
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction
  function automatic logic [5:0] mdays(input logic [4:0] mo, input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    case (mo)
      5'h02:                      mdays = leap ? 6'h29 : 6'h28;
      5'h04, 5'h06, 5'h09, 5'h11: mdays = 6'h30;
      default:                    mdays = 6'h31;
    endcase
  endfunction

  always_comb begin
    logic day_c;
    day_c   = 1'b0;
    next_tm = tm;
    next_dt = dt;
    next_tm.sc = 7'(bcd_inc({1'b0, tm.sc}));
    if (tm.sc == 7'h59) begin
      next_tm.sc = 7'h00;
      next_tm.mn = 7'(bcd_inc({1'b0, tm.mn}));
      if (tm.mn == 7'h59) begin
        next_tm.mn = 7'h00;
        next_tm.hr = 6'(bcd_inc({2'b00, tm.hr}));
        if (ctrl[CTL_FMT12]) begin
          if (tm.hr == 6'h12) next_tm.hr = 6'h01;
          if (tm.hr == 6'h11) begin
            next_tm.pm = !tm.pm;
            day_c      = tm.pm;
          end
        end else if (tm.hr == 6'h23) begin
          next_tm.hr = 6'h00;
          day_c      = 1'b1;
        end
      end
    end
    if (day_c) begin
      next_dt.wd = (dt.wd == 3'h7) ? 3'h1 : dt.wd + 3'h1;
      next_dt.dy = 6'(bcd_inc({2'b00, dt.dy}));
      if (dt.dy == mdays(dt.mo, dt.yr)) begin
        next_dt.dy = 6'h01;
        next_dt.mo = (dt.mo == 5'h12) ? 5'h01 : 5'(bcd_inc({3'b000, dt.mo}));
        if (dt.mo == 5'h12) next_dt.yr = (dt.yr == 8'h99) ? 8'h00 : bcd_inc(dt.yr);
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      tm <= RST_TIME;
      dt <= RST_DATE;
    end else begin
      if (wr_tm) tm <= wdata_i & TM_CMP_MASK;
      else if (tick) tm <= next_tm;
      if (wr_dt) dt <= wdata_i & 32'h00ff_ff3f;
      else if (tick) dt <= next_dt;
    end
  end

  // --------------------------------------------------------
  // Alarm, tamper, timestamp
  // --------------------------------------------------------
  assign alr_ev = tick && ctrl[CTL_ALREN] && next_tm == alarm;

  logic [N_TAMP-1:0][3:0] tflt;
  logic [N_TAMP-1:0]      tlat;
  logic [3:0]             tthr;
  assign tthr = 4'h1 << ctrl[CTL_FILT +: 2];
  for (genvar g = 0; g < N_TAMP; g++) begin : g_tamp
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
        tflt[g] <= 4'h0;
        tlat[g] <= 1'b0;
      end else if (ce_i) begin
        if (!tamp_i[g] || !ctrl[CTL_TAMPEN + g]) begin
          tflt[g] <= 4'h0;
          tlat[g] <= 1'b0;
        end else if (tflt[g] + 4'h1 >= tthr) begin
          tlat[g] <= 1'b1;
        end else begin
          tflt[g] <= tflt[g] + 4'h1;
        end
      end
    end
    // One event per qualified assertion of the pin
    assign tmp_ev[g] = ce_i && tamp_i[g] && ctrl[CTL_TAMPEN + g] && !tlat[g]
                       && tflt[g] + 4'h1 >= tthr;
  end

  logic ts_q;
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) ts_q <= 1'b0;
    else if (ce_i) ts_q <= ts_i;
  end
  assign ts_ev = ce_i && ((ctrl[CTL_TSEN] && ts_i && !ts_q) || (ctrl[CTL_TAMPTS] && |tmp_ev));

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      ts_tm <= RST_TIME;
      ts_dt <= RST_DATE;
      ts_ss <= 15'h0000;
    end else if (ts_ev) begin
      ts_tm <= tm;
      ts_dt <= dt;
      ts_ss <= ss_cnt;
    end
  end

  // --------------------------------------------------------
  // Status, interrupt, wake-up
  // --------------------------------------------------------
  assign ev = {tmp_ev, ts_ev, alr_ev};
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) sts <= '0;
    else if (ce_i) begin
      sts <= (sts & ~((we && addr_i == OFS_STS) ? wdata_i[NS-1:0] : '0)) | ev;
    end
  end
  assign irq_o  = |(sts & msk);
  assign wake_o = |sts;

  // --------------------------------------------------------
  // Read port
  // --------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) rdata_o <= 32'h0000_0000;
    else if (ce_i) begin
      rdata_o <= 32'h0000_0000;
      if (rd_i) begin
        case (addr_i)
          OFS_TIME:  rdata_o <= tm;
          OFS_DATE:  rdata_o <= dt;
          OFS_CTRL:  rdata_o <= ctrl;
          OFS_PRESC: rdata_o <= {9'h000, prea, 1'b0, pres};
          OFS_SUBS:  rdata_o <= {17'h00000, ss_cnt};
          OFS_CALIB: rdata_o <= {23'h000000, calm};
          OFS_ALARM: rdata_o <= alarm;
          OFS_STS:   rdata_o <= 32'(sts);
          OFS_MASK:  rdata_o <= 32'(msk);
          OFS_TSTM:  rdata_o <= ts_tm;
          OFS_TSDT:  rdata_o <= ts_dt;
          OFS_TSSS:  rdata_o <= {17'h00000, ts_ss};
          default: begin
            for (int i = 0; i < N_BKP; i++) begin
              if (addr_i == OFS_BKP + 8'(4 * i)) rdata_o <= bkp[i];
            end
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------
  // Checks
  // --------------------------------------------------------
  chk_bkp_hold:
    assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      !(we && addr_i == OFS_BKP) |=> bkp[0] == $past(bkp[0]))
    else $error("backup word changed without write");
  chk_bkp_read:
    assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      ce_i && rd_i && addr_i == OFS_BKP + 8'h10 |=> rdata_o == $past(bkp[4]))
    else $error("backup word read mismatch");
  chk_sec_wrap:
    assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      tick && !wr_tm && tm.sc == 7'h59 |=> tm.sc == 7'h00 && tm.mn != $past(tm.mn))
    else $error("seconds did not carry");
  chk_hour_fmt:
    assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      ctrl[CTL_FMT12] && tick && !wr_tm && tm.mn == 7'h59 && tm.sc == 7'h59 && tm.hr == 6'h12
      |=> tm.hr == 6'h01)
    else $error("12 hour wrap wrong");
  chk_feb_end:
    assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      tick && !wr_dt && next_tm.hr != tm.hr && dt.mo == 5'h02 && dt.dy == 6'h28 && dt.yr == 8'h23
      && !ctrl[CTL_FMT12] && tm.hr == 6'h23 |=> dt.mo == 5'h03 && dt.dy == 6'h01)
    else $error("february length wrong");
  chk_alarm_flag:
    assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      alr_ev && ce_i |=> sts[STS_ALARM] && wake_o)
    else $error("alarm not flagged");
  chk_shift_add:
    assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      wr_shf && wdata_i[14:0] != 15'h0000 && !wr_tm && !ref_sec
      |=> ss_cnt == 15'($past(ss_cnt) + $past(wdata_i[14:0])))
    else $error("shift not applied");
  chk_cal_mask:
    assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      raw && cal_win == 20'h00000 && calm != 9'h000 |-> !pulse)
    else $error("calibration slot not masked");
  chk_tamp_filt:
    assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      tmp_ev[0] |-> $past(tamp_i[0]) || tthr == 4'h1)
    else $error("tamper passed filter early");
  chk_ts_copy:
    assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      ts_ev |=> ts_tm == $past(tm) && ts_dt == $past(dt) ##1 wake_o || !sts[STS_TS])
    else $error("timestamp not captured");
  chk_ts_wake:
    assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      ts_ev |=> wake_o)
    else $error("timestamp did not wake");
  chk_ref_sec:
    assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      ref_sec && !wr_tm |=> ss_cnt == $past(pres) && apre_cnt == $past(prea))
    else $error("reference second did not realign");
  chk_src_sel:
    assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      ctrl[CTL_SEL +: 2] == CS_LSI && !lsi_tick_i |-> !raw)
    else $error("wrong clock source counted");
endmodule

/* File: dv/bcrb_pins_model.sv */
`timescale 1ns/1ps
module bcrb_pins_model import bcrb_pkg::*; (
  input  wire logic       clk_sys_i,
  output logic            lse_tick_o,
  output logic            ext_tick_o,
  output logic            lsi_tick_o,
  output logic            hse_tick_o,
  output logic            ref_o,
  output logic [1:0]      tamp_o,
  output logic            ts_o
);
  logic [3:0] pulse_q = 4'h0;
  initial begin
    ref_o  = 1'b0;
    tamp_o = 2'h0;
    ts_o   = 1'b0;
  end
  // ----------------------------------------
  // Timekeeper clock edges, one line a source
  // ----------------------------------------
  assign lse_tick_o = pulse_q[0];
  assign ext_tick_o = pulse_q[1];
  assign lsi_tick_o = pulse_q[2];
  assign hse_tick_o = pulse_q[3];
  task automatic tick(input int src, input int n);
    repeat (n) begin
      @(posedge clk_sys_i);
      pulse_q[src] <= 1'b1;
      @(posedge clk_sys_i);
      pulse_q[src] <= 1'b0;
    end
  endtask
  // ----------------------------------------
  // Event pins and reference second
  // ----------------------------------------
  task automatic ref_edges(input int n);
    repeat (n) begin
      @(posedge clk_sys_i);
      ref_o <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      ref_o <= 1'b0;
      @(posedge clk_sys_i);
    end
  endtask
  task automatic ts_rise();
    @(posedge clk_sys_i);
    ts_o <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    ts_o <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic tamp_hold(input int idx, input int cyc);
    @(posedge clk_sys_i);
    tamp_o[idx] <= 1'b1;
    repeat (cyc) @(posedge clk_sys_i);
    tamp_o[idx] <= 1'b0;
    @(posedge clk_sys_i);
  endtask
endmodule

/* File: dv/test_bcd_calendar_rtc_backup.sv */
`timescale 1ns/1ps
module test_bcd_calendar_rtc_backup;
  import bcrb_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        arst_n_i  = 1'b0;
  logic        ce_i      = 1'b1;
  logic [7:0]  addr_i    = 8'h00;
  logic [31:0] wdata_i   = 32'h0;
  logic        wr_i      = 1'b0;
  logic        rd_i      = 1'b0;
  logic [31:0] rdata_o;
  logic        lse, ext, lsi, hse, ref_s, ts_s, irq_o, wake_o;
  logic [1:0]  tamp_s;
  int          error_cnt = 0;
  int          checked   = 0;
  initial forever #20 clk_sys_i = ~clk_sys_i;
  bcrb_rtc i_dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .lse_tick_i(lse),
    .ext_tick_i(ext), .lsi_tick_i(lsi), .hse_tick_i(hse), .ref_i(ref_s), .tamp_i(tamp_s),
    .ts_i(ts_s), .irq_o(irq_o), .wake_o(wake_o));
  bcrb_pins_model i_pins (.clk_sys_i(clk_sys_i), .lse_tick_o(lse), .ext_tick_o(ext),
    .lsi_tick_o(lsi), .hse_tick_o(hse), .ref_o(ref_s), .tamp_o(tamp_s), .ts_o(ts_s));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    wr_i    <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    rd_i   <= 1'b0;
    #1;
    chk(rdata_o, exp, what);
  endtask
  task automatic do_reset(input int n);
    @(posedge clk_sys_i);
    arst_n_i <= 1'b0;
    repeat (n) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_vals();
    rdchk(OFS_TIME, RST_TIME, "time reset");
    rdchk(OFS_DATE, RST_DATE, "date reset");
    rdchk(OFS_CTRL, RST_CTRL, "ctrl reset");
    rdchk(OFS_STS, 32'h0, "status reset");
    rdchk(8'h5c, 32'h0, "unmapped read");
    chk({30'h0, irq_o, wake_o}, 32'h0, "irq wake idle");
    $display("test reset values done");
  endtask
  task automatic t_backup();
    for (int i = 0; i < 5; i++) wr(OFS_BKP + 8'(4 * i), 32'ha5c3_0f10 + 32'(i));
    wr(OFS_CTRL, 32'h2);
    wr(8'h54, 32'hffff_ffff);
    do_reset(3);
    for (int i = 0; i < 5; i++) rdchk(OFS_BKP + 8'(4 * i), 32'ha5c3_0f10 + 32'(i), "backup");
    rdchk(8'h54, 32'h0, "beyond backup");
    rdchk(OFS_CTRL, RST_CTRL, "ctrl after reset");
    $display("test backup done");
  endtask
  task automatic t_calib();
    wr(OFS_CALIB, 32'h1);
    rdchk(OFS_CALIB, 32'h1, "calibration readback");
    wr(OFS_PRESC, 32'h0);
    wr(OFS_CTRL, 32'h1);
    wr(OFS_TIME, 32'h0);
    i_pins.tick(0, 1);
    repeat (4) @(posedge clk_sys_i);
    rdchk(OFS_TIME, 32'h0, "first pulse masked");
    i_pins.tick(0, 1);
    repeat (4) @(posedge clk_sys_i);
    rdchk(OFS_TIME, 32'h1, "next pulse counted");
    $display("test calibration done");
  endtask
  task automatic t_rollover();
    logic [31:0] ct[9] = '{32'h1, 32'h1, 32'h1, 32'h1, 32'h1, 32'h1, 32'h3, 32'h3, 32'h3};
    logic [31:0] ti[9] = '{32'h0023_5959, 32'h0023_5959, 32'h0023_5959, 32'h0023_5959,
                           32'h0023_5959, 32'h0023_5959, 32'h0011_5959, 32'h0051_5959, 32'h0012_5959};
    logic [31:0] to[9] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0052_0000, 32'h0012_0000, 32'h0001_0000};
    logic [31:0] di[9] = '{32'h0023_2228, 32'h0024_2228, 32'h0024_2229, 32'h0023_2430,
                           32'h0023_2131, 32'h0023_f231, 32'h0023_2115, 32'h0023_2115, 32'h0023_2115};
    logic [31:0] dn[9] = '{32'h0023_4301, 32'h0024_4229, 32'h0024_4301, 32'h0023_4501,
                           32'h0023_4201, 32'h0024_2101, 32'h0023_2115, 32'h0023_4116, 32'h0023_2115};
    wr(OFS_PRESC, 32'h0);
    for (int i = 0; i < 9; i++) begin
      wr(OFS_CTRL, ct[i]);
      wr(OFS_DATE, di[i]);
      wr(OFS_TIME, ti[i]);
      i_pins.tick(0, 1);
      repeat (4) @(posedge clk_sys_i);
      rdchk(OFS_TIME, to[i], "time carry");
      rdchk(OFS_DATE, dn[i], "date carry");
    end
    @(posedge clk_sys_i);
    ce_i <= 1'b0;
    wr(OFS_TIME, 32'h0);
    i_pins.tick(0, 1);
    ce_i <= 1'b1;
    rdchk(OFS_TIME, to[8], "frozen by enable");
    $display("test rollover done");
  endtask
  task automatic t_sources();
    for (int s = 0; s < 4; s++) begin
      wr(OFS_CTRL, 32'h1 | 32'(s << CTL_SEL));
      wr(OFS_TIME, 32'h0);
      i_pins.tick((s + 1) % 4, 32);
      repeat (4) @(posedge clk_sys_i);
      rdchk(OFS_TIME, 32'h0, "other source ignored");
      i_pins.tick(s, (s == 3) ? 32 : 1);
      repeat (4) @(posedge clk_sys_i);
      rdchk(OFS_TIME, 32'h1, "selected source ticks");
    end
    $display("test clock sources done");
  endtask
  task automatic t_alarm();
    wr(OFS_CTRL, 32'h41);
    wr(OFS_ALARM, 32'h2);
    wr(OFS_TIME, 32'h0);
    i_pins.tick(0, 1);
    repeat (4) @(posedge clk_sys_i);
    rdchk(OFS_STS, 32'h0, "no early alarm");
    i_pins.tick(0, 1);
    repeat (4) @(posedge clk_sys_i);
    chk({30'h0, irq_o, wake_o}, 32'h1, "alarm wakes masked irq low");
    wr(OFS_MASK, 32'h1);
    #1 chk({30'h0, irq_o, wake_o}, 32'h3, "alarm irq unmasked");
    wr(OFS_STS, 32'h1);
    #1 chk({30'h0, irq_o, wake_o}, 32'h0, "alarm cleared");
    $display("test alarm done");
  endtask
  task automatic t_stamp();
    wr(OFS_CTRL, 32'h1381);
    wr(OFS_DATE, 32'h0023_2115);
    wr(OFS_TIME, 32'h0012_3456);
    i_pins.ts_rise();
    repeat (3) @(posedge clk_sys_i);
    chk({31'h0, wake_o}, 32'h1, "stamp wakes");
    rdchk(OFS_STS, 32'h2, "stamp flag");
    rdchk(OFS_TSTM, 32'h0012_3456, "stamp time");
    rdchk(OFS_TSDT, 32'h0023_2115, "stamp date");
    wr(OFS_STS, 32'hf);
    wr(OFS_CTRL, 32'h1781);
    i_pins.tamp_hold(1, 1);
    repeat (3) @(posedge clk_sys_i);
    rdchk(OFS_STS, 32'h0, "short glitch filtered");
    i_pins.tamp_hold(1, 4);
    repeat (3) @(posedge clk_sys_i);
    rdchk(OFS_STS, 32'ha, "tamper and stamp");
    chk({31'h0, wake_o}, 32'h1, "tamper wakes");
    wr(OFS_STS, 32'hf);
    i_pins.tamp_hold(0, 4);
    repeat (3) @(posedge clk_sys_i);
    rdchk(OFS_STS, 32'h6, "tamper zero and stamp");
    wr(OFS_STS, 32'hf);
    $display("test timestamp and tamper done");
  endtask
  task automatic t_shift();
    wr(OFS_CTRL, 32'h1);
    wr(OFS_PRESC, 32'h0000_00ff);
    wr(OFS_TIME, 32'h0000_0007);
    wr(OFS_SHIFT, 32'h0);
    rdchk(OFS_SUBS, 32'h0000_00ff, "zero shift ignored");
    wr(OFS_SHIFT, 32'h1);
    rdchk(OFS_SUBS, 32'h0000_0100, "shift one pulse");
    wr(OFS_SHIFT, 32'h7e00);
    rdchk(OFS_SUBS, 32'h0000_7f00, "shift large");
    wr(OFS_SHIFT, 32'h8000_0000);
    repeat (2) @(posedge clk_sys_i);
    rdchk(OFS_TIME, 32'h0000_0008, "add one second");
    $display("test shift done");
  endtask
  task automatic t_refclk();
    wr(OFS_PRESC, 32'h0);
    for (int m = 0; m < 2; m++) begin
      wr(OFS_CTRL, (m == 0) ? 32'h11 : 32'h31);
      wr(OFS_TIME, 32'h0);
      i_pins.tick(0, 2);
      i_pins.ref_edges((m == 0) ? 49 : 59);
      repeat (3) @(posedge clk_sys_i);
      rdchk(OFS_TIME, 32'h0, "no tick before last edge");
      i_pins.ref_edges(1);
      repeat (3) @(posedge clk_sys_i);
      rdchk(OFS_TIME, 32'h1, "reference second");
    end
    $display("test reference done");
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    t_reset_vals();
    t_backup();
    t_calib();
    t_rollover();
    t_sources();
    t_alarm();
    t_stamp();
    t_shift();
    t_refclk();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    error_cnt++;
    $display("unexpected at %0t: run did not finish", $time);
    give_verdict();
  end
endmodule
